// ---- design/lmr_cfg.svh ----
`ifndef LMR_CFG_SVH
`define LMR_CFG_SVH

// Register offsets
`define LMR_A_CTRL   8'h00
`define LMR_A_MSCTL  8'h04
`define LMR_A_STAT   8'h08
`define LMR_A_EXP    8'h0c
`define LMR_A_LPA    8'h10
`define LMR_A_SEED   8'h14

// Control register fields
`define LMR_CTRL_ANEN 0
`define LMR_CTRL_RSTA 1
`define LMR_CTRL_SS0  2
`define LMR_CTRL_SS1  3
`define LMR_CTRL_DPX  4
`define LMR_CTRL_INIT 5'h01

// Master/slave control fields
`define LMR_MS_MANEN  0
`define LMR_MS_MANVAL 1
`define LMR_MS_INIT   2'h0

// Speed codes
`define LMR_SPD_10   2'h0
`define LMR_SPD_100  2'h1
`define LMR_SPD_1000 2'h2

// Partner ability bits for detected legacy speed
`define LMR_LPA_10HD  5
`define LMR_LPA_100HD 7

// Seed generator
`define LMR_SEED_INIT 11'h5a5

// Parallel detect qualify time
`define LMR_CLK_NS     10
`define LMR_PD_QUAL_NS 100000

`endif

// ---- design/lmr_pkg.sv ----
package lmr_pkg;

  // Link state machine
  typedef enum logic [1:0] {
    LMR_DOWN,
    LMR_PD,
    LMR_UP,
    LMR_FORCED
  } lmr_state_t;

endpackage

// ---- design/lmr_sync.sv ----
`timescale 1ns/1ps
module lmr_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous levels in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lmr_sync_t;

  lmr_sync_t r_q;
  lmr_sync_t r_d;

  // Two stage shift
  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;

endmodule

// ---- design/lmr_ms_resolve.sv ----
`timescale 1ns/1ps
module lmr_ms_resolve (
  // Local advertisement
  input  wire logic        loc_man,
  input  wire logic        loc_val,
  input  wire logic        loc_multi,
  input  wire logic [10:0] loc_seed,
  // Partner advertisement
  input  wire logic        lp_man,
  input  wire logic        lp_val,
  input  wire logic        lp_multi,
  input  wire logic [10:0] lp_seed,
  // Outcome
  output logic             master,
  output logic             fault,
  output logic             no_link
);

  // Role resolution table
  always_comb begin
    master  = 1'b0;
    fault   = 1'b0;
    no_link = 1'b0;
    if (loc_man && lp_man) begin
      if (loc_val == lp_val) begin
        fault   = 1'b1;
        no_link = 1'b1;
      end else begin
        master = loc_val;
      end
    end else if (loc_man) begin
      master = loc_val;
    end else if (lp_man) begin
      master = !lp_val;
    end else if (loc_multi != lp_multi) begin
      master = loc_multi;
    end else if (loc_seed == lp_seed) begin
      no_link = 1'b1;                // Seed tie, retry
    end else begin
      master = loc_seed > lp_seed;
    end
  end

endmodule

// ---- design/lmr_top.sv ----
// Operation
// - No FLP seen: speed from MLT-3 or link pulses, link is half duplex.
// - Link via parallel detect clears partner-negotiation-able status bit.
// - Fault during parallel detect sets parallel-detect-fault status bit.
// - Partner ability register loads the code word from partner bursts.
// - Legacy partner: ability register shows detected speed after detect.
// - Parallel detect never brings up a gigabit link.
// - Gigabit: one side master on local clock, other slave.
// - Role from strap, or from manual value when manual enable set.
// - Both sides manual with same role sets configuration fault bit.
// - Manual side wins over non-manual; identical manual roles give no link.
// - Multi-port beats single-port; same port type settled by random seed.
// - Forced 10/100 and duplex apply only while negotiation is disabled.
// - Forced link state follows two speed-select bits and duplex bit.
// - Forcing gigabit is not supported; gigabit only via negotiation.
// - Half duplex: carrier sense on tx and rx; rx during tx collides.
// - Full duplex: no collision; carrier sense follows receive only.
// - Gigabit keeps internal carrier sense low.
// - Active mode follows line carrier; low mode stays low.
// - Speed-select and duplex bits ignored while negotiation is enabled.
`timescale 1ns/1ps
`include "lmr_cfg.svh"
module lmr_top
  import lmr_pkg::*;
#(
  parameter int PD_CYC = `LMR_PD_QUAL_NS / `LMR_CLK_NS
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        SRST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // Configuration straps
  input  wire logic        AN_STRAP,
  input  wire logic        MULTI_STRAP,
  // Line detectors
  input  wire logic        FLP_DET,
  input  wire logic        NLP_DET,
  input  wire logic        MLT3_DET,
  input  wire logic        LINK_LOSS,
  // Negotiation result
  input  wire logic        AN_DONE,
  input  wire logic [1:0]  AN_SPEED,
  input  wire logic        AN_FDX,
  input  wire logic [15:0] LP_WORD,
  input  wire logic        LP_MS_MAN,
  input  wire logic        LP_MS_VAL,
  input  wire logic        LP_MULTI,
  input  wire logic [10:0] LP_SEED,
  // MAC side activity
  input  wire logic        TX_ACT,
  input  wire logic        RX_ACT,
  // Resolved link
  output logic             LINK_UP,
  output logic      [1:0]  SPEED,
  output logic             FULL_DUPLEX,
  output logic             MASTER,
  output logic             CRS,
  output logic             COL
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    lmr_state_t  st;
    logic [4:0]  ctrl;
    logic [1:0]  msctl;
    logic        link;
    logic [1:0]  spd;
    logic        dpx;
    logic        mst;
    logic        ms_flt;
    logic        pd_flt;
    logic        lp_an;
    logic [15:0] lpa;
    logic [1:0]  pd_spd;
    logic [15:0] cnt;
    logic [10:0] seed;
    logic        crs;
    logic        col;
    logic [15:0] rdata;
  } lmr_top_t;

  lmr_top_t q;
  lmr_top_t d;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match for a strobe
  function automatic logic hit(input logic stb,
                               input logic [7:0] a,
                               input logic [7:0] off);
    hit = stb && (a == off);
  endfunction

  // Partner ability bit for a legacy speed
  function automatic logic [15:0] pd_word(input logic [1:0] s);
    pd_word = '0;
    if (s == `LMR_SPD_100) begin
      pd_word[`LMR_LPA_100HD] = 1'b1;
    end else begin
      pd_word[`LMR_LPA_10HD] = 1'b1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Strap synchroniser

  logic [1:0] strap_s;

  lmr_sync #(
    .W (2)
  ) u_strap (
    .clk (MCLK),
    .rst (SRST),
    .d   ({MULTI_STRAP, AN_STRAP}),
    .q   (strap_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Master/slave resolution

  logic ms_master;
  logic ms_fault;
  logic ms_nolink;

  lmr_ms_resolve u_ms (
    .loc_man   (q.msctl[`LMR_MS_MANEN]),
    .loc_val   (q.msctl[`LMR_MS_MANVAL]),
    .loc_multi (strap_s[1]),
    .loc_seed  (q.seed),
    .lp_man    (LP_MS_MAN),
    .lp_val    (LP_MS_VAL),
    .lp_multi  (LP_MULTI),
    .lp_seed   (LP_SEED),
    .master    (ms_master),
    .fault     (ms_fault),
    .no_link   (ms_nolink)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decodes

  logic       an_en;
  logic       restart;
  logic [1:0] f_spd;

  // Negotiation off by strap or by register
  assign an_en   = q.ctrl[`LMR_CTRL_ANEN] && strap_s[0];
  assign restart = hit(WR, ADDR, `LMR_A_CTRL) &&
                   WDATA[`LMR_CTRL_RSTA];
  assign f_spd   = {q.ctrl[`LMR_CTRL_SS1], q.ctrl[`LMR_CTRL_SS0]};

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d       = q;
    d.rdata = '0;

    // Seed generator runs free
    d.seed = {q.seed[9:0], q.seed[10] ^ q.seed[8]};

    // Read mux
    if (RD) begin
      unique case (ADDR)
        `LMR_A_CTRL:  d.rdata = {11'h000, q.ctrl};
        `LMR_A_MSCTL: d.rdata = {14'h0000, q.msctl};
        `LMR_A_STAT:  d.rdata = {9'h000, (q.st == LMR_FORCED),
                                 q.ms_flt, q.mst, q.dpx, q.spd, q.link};
        `LMR_A_EXP:   d.rdata = {14'h0000, q.pd_flt, q.lp_an};
        `LMR_A_LPA:   d.rdata = q.lpa;
        `LMR_A_SEED:  d.rdata = {5'h00, q.seed};
        default:      d.rdata = '0;
      endcase
    end

    // Fault flags clear on read, set below wins
    if (hit(RD, ADDR, `LMR_A_STAT)) begin
      d.ms_flt = 1'b0;
    end
    if (hit(RD, ADDR, `LMR_A_EXP)) begin
      d.pd_flt = 1'b0;
    end

    // Register writes, restart bit self clears
    if (hit(WR, ADDR, `LMR_A_CTRL)) begin
      d.ctrl = WDATA[4:0];
      d.ctrl[`LMR_CTRL_RSTA] = 1'b0;
    end
    if (hit(WR, ADDR, `LMR_A_MSCTL)) begin
      d.msctl = WDATA[1:0];
    end

    // Link state machine
    unique case (q.st)
      LMR_DOWN: begin
        d.link = 1'b0;
        d.cnt  = '0;
        if (!an_en) begin
          d.st = LMR_FORCED;
        end else if (AN_DONE) begin
          d.lp_an = 1'b1;
          d.lpa   = LP_WORD;
          if (AN_SPEED == `LMR_SPD_1000) begin
            if (ms_fault) begin
              d.ms_flt = 1'b1;
            end
            if (!ms_nolink) begin
              d.st   = LMR_UP;
              d.link = 1'b1;
              d.spd  = `LMR_SPD_1000;
              d.dpx  = AN_FDX;
              d.mst  = ms_master;
            end
          end else begin
            d.st   = LMR_UP;
            d.link = 1'b1;
            d.spd  = AN_SPEED;
            d.dpx  = AN_FDX;
            d.mst  = 1'b0;
          end
        end else if (!FLP_DET && NLP_DET && MLT3_DET) begin
          d.pd_flt = 1'b1;
        end else if (!FLP_DET && (NLP_DET || MLT3_DET)) begin
          d.st     = LMR_PD;
          d.pd_spd = MLT3_DET ? `LMR_SPD_100 : `LMR_SPD_10;
        end
      end

      LMR_PD: begin
        d.cnt = q.cnt + 16'h0001;
        if (!an_en || restart || FLP_DET) begin
          d.st = LMR_DOWN;
        end else if (NLP_DET && MLT3_DET) begin
          d.pd_flt = 1'b1;
          d.st     = LMR_DOWN;
        end else if (!NLP_DET && !MLT3_DET) begin
          d.st = LMR_DOWN;
        end else if ((q.pd_spd == `LMR_SPD_100) != MLT3_DET) begin
          d.pd_flt = 1'b1;
          d.st     = LMR_DOWN;
        end else if (q.cnt == 16'(PD_CYC - 1)) begin
          d.st    = LMR_UP;
          d.link  = 1'b1;
          d.spd   = q.pd_spd;
          d.dpx   = 1'b0;
          d.mst   = 1'b0;
          d.lp_an = 1'b0;
          d.lpa   = pd_word(q.pd_spd);
        end
      end

      LMR_UP: begin
        // Outcome held until link drop, restart or negotiation disable
        if (LINK_LOSS || restart || !an_en) begin
          d.st   = LMR_DOWN;
          d.link = 1'b0;
          d.mst  = 1'b0;                      // Role only while linked
        end
      end

      LMR_FORCED: begin
        d.mst = 1'b0;
        d.spd = f_spd;
        d.dpx = q.ctrl[`LMR_CTRL_DPX];
        if (an_en) begin
          d.st   = LMR_DOWN;
          d.link = 1'b0;
        end else if (f_spd == `LMR_SPD_1000 ||
                     f_spd == 2'h3) begin
          d.link = 1'b0;
        end else begin
          d.link = !LINK_LOSS;
        end
      end
    endcase

    // Internal carrier sense and collision
    if (!q.link || q.spd == `LMR_SPD_1000) begin
      d.crs = 1'b0;
      d.col = 1'b0;
    end else if (q.dpx) begin
      d.crs = RX_ACT;
      d.col = 1'b0;
    end else begin
      d.crs = RX_ACT || TX_ACT;
      d.col = RX_ACT && TX_ACT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Low mode while reset or link down
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      q        <= '0;
      q.st     <= LMR_DOWN;
      q.ctrl   <= `LMR_CTRL_INIT;
      q.msctl  <= `LMR_MS_INIT;
      q.seed   <= `LMR_SEED_INIT;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA       = q.rdata;
  assign LINK_UP     = q.link;
  assign SPEED       = q.spd;
  assign FULL_DUPLEX = q.dpx;
  assign MASTER      = q.mst;
  assign CRS         = q.crs;
  assign COL         = q.col;

endmodule

// ---- verification/lmr_properties.sv ----
`timescale 1ns/1ps
module lmr_properties (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       SRST,
  // Stimulus
  input wire logic       WR,
  input wire logic       LINK_LOSS,
  input wire logic       FLP_DET,
  input wire logic       AN_DONE,
  input wire logic [1:0] AN_SPEED,
  input wire logic       AN_FDX,
  input wire logic       TX_ACT,
  input wire logic       RX_ACT,
  // Resolved link
  input wire logic       LINK_UP,
  input wire logic [1:0] SPEED,
  input wire logic       FULL_DUPLEX,
  input wire logic       MASTER,
  input wire logic       CRS,
  input wire logic       COL
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // Link up at 10/100, by duplex
  wire half_m = LINK_UP && !FULL_DUPLEX && SPEED != 2'h2;
  wire full_m = LINK_UP && FULL_DUPLEX && SPEED != 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  AST_HALF_CRS:
    assert property (half_m |=> CRS == $past(TX_ACT | RX_ACT))
    else $error("carrier sense wrong in half duplex");
  AST_HALF_COL:
    assert property (half_m |=> COL == $past(TX_ACT & RX_ACT))
    else $error("collision wrong in half duplex");
  AST_FULL_CRS:
    assert property (full_m |=> CRS == $past(RX_ACT) && !COL)
    else $error("carrier sense wrong in full duplex");
  AST_GIG_QUIET:
    assert property ((!LINK_UP || SPEED == 2'h2) |=> !CRS && !COL)
    else $error("carrier sense not low");
  AST_NO_FORCED_GIG:
    assert property ($rose(LINK_UP) && SPEED == 2'h2 |-> $past(AN_DONE))
    else $error("gigabit link without negotiation");
  AST_MASTER_GIG:
    assert property (MASTER && LINK_UP |-> SPEED == 2'h2)
    else $error("master role below gigabit");
  AST_AN_RESULT:
    assert property (AN_DONE && FLP_DET && !LINK_UP && AN_SPEED != 2'h2
      |=> LINK_UP && SPEED == $past(AN_SPEED) && FULL_DUPLEX == $past(AN_FDX))
    else $error("negotiated result not taken");
  AST_HOLD:
    assert property (LINK_UP && !LINK_LOSS && !WR && !$past(WR) && !AN_DONE
      |=> LINK_UP && $stable(SPEED) && $stable(FULL_DUPLEX) && $stable(MASTER))
    else $error("link outcome not held");
  // Main scenarios
  cover property (COL);
  cover property (LINK_UP && MASTER);
  cover property (LINK_UP && !FULL_DUPLEX && SPEED == 2'h1);
endmodule
bind lmr_top lmr_properties lmr_properties_i (.MCLK, .SRST, .WR, .LINK_LOSS,
  .FLP_DET, .AN_DONE, .AN_SPEED, .AN_FDX, .TX_ACT, .RX_ACT, .LINK_UP, .SPEED,
  .FULL_DUPLEX, .MASTER, .CRS, .COL);

// ---- verification/lmr_partner.sv ----
`timescale 1ns/1ps
module lmr_partner (
  // Clock
  input wire logic   MCLK,
  // Line detectors
  output logic       FLP_DET,
  output logic       NLP_DET,
  output logic       MLT3_DET,
  output logic       LINK_LOSS,
  // Negotiation result
  output logic       AN_DONE,
  output logic [1:0] AN_SPEED,
  output logic       AN_FDX,
  output logic [15:0] LP_WORD,
  output logic       LP_MS_MAN,
  output logic       LP_MS_VAL,
  output logic       LP_MULTI,
  output logic [10:0] LP_SEED
);
  // Cable unplugged at start
  initial begin
    {FLP_DET, NLP_DET, MLT3_DET, AN_DONE, AN_SPEED, AN_FDX} = '0;
    {LP_WORD, LP_MS_MAN, LP_MS_VAL, LP_MULTI, LP_SEED} = '0;
    LINK_LOSS = 1'b1;
  end
  // Legacy partner: no bursts, detector levels as given
  task automatic legacy(input logic nlp, input logic mlt3);
    @(posedge MCLK);
    {FLP_DET, NLP_DET, MLT3_DET, LINK_LOSS} <= {1'b0, nlp, mlt3, 1'b0};
  endtask
  // Negotiating partner: bursts, then one result pulse
  task automatic negotiate(input logic [1:0] spd, input logic fdx,
    input logic [15:0] w, input logic [2:0] ms, input logic [10:0] sd);
    @(posedge MCLK);
    {FLP_DET, NLP_DET, MLT3_DET, LINK_LOSS} <= 4'h8;
    @(posedge MCLK);
    {AN_DONE, AN_SPEED, AN_FDX, LP_WORD} <= {1'b1, spd, fdx, w};
    {LP_MS_MAN, LP_MS_VAL, LP_MULTI, LP_SEED} <= {ms, sd};
    @(posedge MCLK);
    // Result fields no longer valid
    {AN_DONE, LP_WORD, LP_SEED} <= {1'b0, ~w, ~sd};
  endtask
  // Signal lost, lines quiet
  task automatic drop();
    @(posedge MCLK);
    {FLP_DET, NLP_DET, MLT3_DET, LINK_LOSS} <= 4'h1;
    repeat (2) @(posedge MCLK);
  endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`include "lmr_cfg.svh"
module testbench;
  logic        MCLK, SRST, WR, RD, AN_STRAP, MULTI_STRAP, TX_ACT, RX_ACT;
  logic [7:0]  ADDR;
  logic [15:0] WDATA, RDATA, LP_WORD, v;
  logic [10:0] LP_SEED;
  logic [1:0]  AN_SPEED, SPEED;
  logic        FLP_DET, NLP_DET, MLT3_DET, LINK_LOSS, AN_DONE, AN_FDX;
  logic        LP_MS_MAN, LP_MS_VAL, LP_MULTI, LINK_UP, FULL_DUPLEX;
  logic        MASTER, CRS, COL;
  int          num_errors, n_compared, seed, i, k, e, q;
  lmr_top #(.PD_CYC(8)) lmr_top_i (.*);
  lmr_partner lmr_partner_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge MCLK);
    {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge MCLK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // Bounded wait for link level
  task automatic wait_up(input logic exp);
    for (k = 0; k < 40 && LINK_UP !== exp; k++) @(posedge MCLK);
    #1;
  endtask
  // Role model: 0 slave, 1 master, 2 no link; 0 single 1 multi 2 manM 3 manS
  function automatic int role(int l, int p, int tie);
    if (l >= 2 && p >= 2) return (l == p) ? 2 : (l == 2);
    if (l >= 2) return l == 2;
    if (p >= 2) return p == 3;
    return (l == p) ? tie : (l == 1);
  endfunction
  task automatic print_verdict();
    $display("compared %0d, wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  // Tests
  initial begin
    seed = 68;
    {SRST, AN_STRAP, MULTI_STRAP, WR, RD, TX_ACT, RX_ACT} = 7'h60;
    {ADDR, WDATA} = '0;
    repeat (3) @(posedge MCLK);
    SRST <= 1'b0;
    repeat (5) @(posedge MCLK);
    rd(`LMR_A_CTRL);
    chk(v, 16'h0001);
    rd(8'h3c);
    chk(v, 16'h0000);
    $display("test registers done");
    for (i = 0; i < 2; i++) begin
      lmr_partner_i.legacy(i == 0, i == 1);
      wait_up(1'b1);
      chk({LINK_UP, SPEED, FULL_DUPLEX}, {2'b10, i[0], 1'b0});
      rd(`LMR_A_EXP);
      chk(v[0], 1'b0);
      rd(`LMR_A_LPA);
      chk({v[`LMR_LPA_100HD], v[`LMR_LPA_10HD]}, {i[0], !i[0]});
      lmr_partner_i.drop();
    end
    lmr_partner_i.legacy(1'b1, 1'b1);
    repeat (4) @(posedge MCLK);
    rd(`LMR_A_EXP);
    chk({LINK_UP, v[1]}, 2'b01);
    lmr_partner_i.drop();
    rd(`LMR_A_EXP);
    chk(v[1], 1'b1);
    rd(`LMR_A_EXP);
    chk(v[1], 1'b0);
    $display("test parallel detect done");
    for (i = 0; i < 16; i++) begin
      MULTI_STRAP <= (i / 4 == 1);
      wr(`LMR_A_MSCTL, {14'h0, i / 4 == 2, i / 4 >= 2});
      q = $random(seed);
      e = role(i / 4, i % 4, q & 1);
      {TX_ACT, RX_ACT} <= q[17:16];
      lmr_partner_i.negotiate(`LMR_SPD_1000, 1'b1, q[15:0],
        {i % 4 >= 2, i % 4 == 2, i % 4 == 1}, q[0] ? 11'h000 : 11'h7ff);
      wait_up(e != 2);
      chk({LINK_UP, MASTER}, e == 2 ? 2'h0 : {1'b1, e[0]});
      rd(`LMR_A_STAT);
      chk(v[5], e == 2 && i / 4 >= 2);
      rd(`LMR_A_LPA);
      if (e != 2) chk(v, q[15:0]);
      lmr_partner_i.drop();
    end
    $display("test master slave done");
    for (i = 0; i < 4; i++) begin
      wr(`LMR_A_CTRL, 16'h001d);
      lmr_partner_i.negotiate({1'b0, i[1]}, i[0], 16'h0, 3'h0, 11'h0);
      wait_up(1'b1);
      chk({SPEED, FULL_DUPLEX, MASTER}, {1'b0, i[1:0], 1'b0});
      for (k = 0; k < 20; k++) begin
        @(posedge MCLK);
        #1;
        if (k > 0) chk({CRS, COL}, i[0] ? {q[0], 1'b0} : {|q[1:0], &q[1:0]});
        q = $random(seed);
        {TX_ACT, RX_ACT} <= q[1:0];
      end
      wr(`LMR_A_CTRL, 16'h0003);
      wait_up(1'b0);
      chk(LINK_UP, 1'b0);
    end
    $display("test duplex done");
    for (i = 0; i < 8; i++) begin
      wr(`LMR_A_CTRL, {11'h0, i[0], i[2:1], 2'b00});
      lmr_partner_i.legacy(1'b0, 1'b0);
      repeat (4) @(posedge MCLK);
      #1;
      chk(LINK_UP, i < 4);
      if (i < 4) chk({SPEED, FULL_DUPLEX}, i[2:0]);
    end
    $display("test forced done");
    print_verdict();
  end
endmodule
